// ### verilog/clkgen_defs.svh
// register offsets, reset values, field positions and write masks of the clock generator.
// assumes byte addressing on a 32-bit classic Wishbone bus, one aligned word per register.
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CG_OFS_BUS_EN 8'h04
`define CG_OFS_PERIPH_EN 8'h08
`define CG_OFS_SRC_SEL 8'h10
`define CG_OFS_DIV_FIRST 8'h14
`define CG_OFS_DIV_SECOND 8'h18
`define CG_OFS_PLL 8'h20
`define CG_OFS_STATUS 8'h24

// ----------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------
`define CG_RST_BUS_EN 32'h0000_0003
`define CG_RST_PERIPH_EN 32'h0000_0007
`define CG_RST_SRC_SEL 32'h0000_0000
`define CG_RST_DIV_FIRST 32'h0000_0000
`define CG_RST_DIV_SECOND 32'h0000_0000
`define CG_RST_PLL 32'h0001_4035
`define CG_MASK_BUS_EN 32'h0000_0043
`define CG_MASK_PERIPH_EN 32'h0000_037F
`define CG_MASK_SRC_SEL 32'h0000_C0FF
`define CG_MASK_DIV_FIRST 32'h00FF_FFCF
`define CG_MASK_DIV_SECOND 32'h00FF_0000
`define CG_MASK_PLL 32'h0007_FFFF

// ----------------------------------------------------------------
// peripheral clock enable bits
// ----------------------------------------------------------------
`define CONVERTER_CLOCK_ON 9
`define SERIAL_PERIPH_CLOCK_ON 8
`define TWO_WIRE_CLOCK_ON 6
`define PULSE_WIDTH_CLOCK_ON 5
`define SECOND_SERIAL_CLOCK_ON 4
`define FIRST_SERIAL_CLOCK_ON 3
`define CALENDAR_IFACE_CLOCK_ON 2
`define WATCHDOG_CLOCK_ON 1
`define TIMER_CLOCK_ON 0
`define PERIPH_GATES 10
`define PERIPH_SPARE 7

// ----------------------------------------------------------------
// bus clock enable bits
// ----------------------------------------------------------------
`define USB_DEVICE_CLOCK_ON 6
`define PERIPH_BUS_CLOCK_ON 1
`define PROCESSOR_CLOCK_ON 0

// ----------------------------------------------------------------
// source select and divider fields
// ----------------------------------------------------------------
`define CONVERTER_SRC_SEL 15:14
`define SERIAL_SRC_SEL 7:6
`define AUDIO_SRC_SEL 5:4
`define USB_SRC_SEL 3:2
`define CORE_BUS_SRC_SEL 1:0
`define USB_DIV 23:20
`define SERIAL_DIV 19:16
`define AUDIO_DIV 15:8
`define PERIPH_BUS_DIV 7:6
`define CORE_BUS_DIV 3:0
`define CONVERTER_DIV 23:16

// ----------------------------------------------------------------
// pll control fields
// ----------------------------------------------------------------
`define PLL_OUT_OFF 18
`define PLL_BYPASS 17
`define PLL_POWER_DOWN 16
`define PLL_POST_DIV 15:14
`define PLL_REF_DIV 13:9
`define PLL_LOOP_DIV 8:0

`endif

// ### verilog/clkgen_pkg.sv
// types shared by the clock generator and its dividers.
// assumes nothing beyond a SystemVerilog compiler.
package clkgen_pkg;

  // ----------------------------------------------------------------
  // clock source choices, in the order of the two-bit select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_XTAL,
    SRC_PLL,
    SRC_PLL_HALF,
    SRC_RTC32
  } src_t;

endpackage : clkgen_pkg

// ### verilog/clock_divider.sv
// source multiplexer and integer divider for one clock domain.
// assumes edge_i carries one-cycle pulses on every edge of each candidate source.
module clock_divider
  import clkgen_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] edge_i,
  input wire src_t sel_i,
  input wire logic [W-1:0] div_i,
  input wire logic halve_i,
  output logic clk_o,
  output logic edge_o,
  output logic pending_o
);

  localparam int CW = W + 2;

  src_t sel_cur_r;
  logic [W-1:0] div_cur_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] limit;
  logic src_edge;
  logic wrap;

  // each output half period spans (div+1) source half periods, twice that when halved
  assign limit = CW'((CW'(div_cur_r) + CW'(1)) << halve_i);
  assign src_edge = edge_i[sel_cur_r];
  assign wrap = src_edge && (cnt_r == limit - CW'(1));

  // ----------------------------------------------------------------
  // counter and output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      clk_o <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      edge_o <= wrap;
      if (wrap) begin
        cnt_r <= '0;
        clk_o <= ~clk_o;
      end else if (src_edge) begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // settings are taken only at a falling output edge
  // ----------------------------------------------------------------
  // the new source then starts a full low phase, so no runt pulse appears;
  // a stopped old source would freeze the switch, hence both must run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_cur_r <= SRC_XTAL;
      div_cur_r <= '0;
    end else if (wrap && clk_o) begin
      sel_cur_r <= sel_i;
      div_cur_r <= div_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= (sel_i != sel_cur_r) || (div_i != div_cur_r);
    end
  end

endmodule : clock_divider

// ### verilog/chip_clock_gen_control.sv
// clock generator: source selection, dividers, clock gates and pll control registers.
// assumes a classic Wishbone master on clk_i and crystal, 32 kHz and pll clocks on pins.
//
// Local design decision: the Wishbone slave port.
`include "clkgen_defs.svh"

module chip_clock_gen_control
  import clkgen_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic xtal_clk_i,
  input wire logic rtc_xtal_clk_i,
  input wire logic pll_clk_i,
  output logic pll_ref_clk_o,
  output logic pll_out_off_o,
  output logic pll_bypass_o,
  output logic pll_power_down_o,
  output logic [1:0] pll_post_div_o,
  output logic [4:0] pll_ref_div_o,
  output logic [8:0] pll_loop_div_o,
  output logic hclk_o,
  output logic cpu_clk_o,
  output logic pclk_o,
  output logic usb_clk_o,
  output logic uart_clk_o,
  output logic audio_clk_o,
  output logic adc_clk_o,
  output logic [`PERIPH_GATES-1:0] periph_clk_o
);

  localparam int NSYNC = 3;
  localparam int NGATE = `PERIPH_GATES + 4;
  localparam int G_CPU = `PERIPH_GATES;
  localparam int G_PCLK = `PERIPH_GATES + 1;
  localparam int G_USB = `PERIPH_GATES + 2;
  localparam int G_ADC = `PERIPH_GATES + 3;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] lanes,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    merge_write = res & mask;
  endfunction : merge_write

  // peripheral selects treat any code with the upper bit set as pll halved
  function automatic src_t periph_src(input logic [1:0] code);
    if (code[1]) begin
      periph_src = SRC_PLL_HALF;
    end else if (code[0]) begin
      periph_src = SRC_PLL;
    end else begin
      periph_src = SRC_XTAL;
    end
  endfunction : periph_src

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] bus_clock_enables_r;
  logic [31:0] peripheral_clock_enables_r;
  logic [31:0] clock_source_select_r;
  logic [31:0] clock_divider_first_r;
  logic [31:0] clock_divider_second_r;
  logic [31:0] pll_control_r;
  logic [31:0] rd_data;
  logic access;
  logic wr;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i;

  // ----------------------------------------------------------------
  // wishbone slave: one wait-free cycle, ack one edge after the request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_clock_enables_r <= `CG_RST_BUS_EN;
    end else if (wr && wb_adr_i == `CG_OFS_BUS_EN) begin
      bus_clock_enables_r <= merge_write(bus_clock_enables_r, wb_dat_i, wb_sel_i,
                                         `CG_MASK_BUS_EN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_clock_enables_r <= `CG_RST_PERIPH_EN;
    end else if (wr && wb_adr_i == `CG_OFS_PERIPH_EN) begin
      peripheral_clock_enables_r <= merge_write(peripheral_clock_enables_r, wb_dat_i,
                                                wb_sel_i, `CG_MASK_PERIPH_EN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_select_r <= `CG_RST_SRC_SEL;
    end else if (wr && wb_adr_i == `CG_OFS_SRC_SEL) begin
      clock_source_select_r <= merge_write(clock_source_select_r, wb_dat_i, wb_sel_i,
                                           `CG_MASK_SRC_SEL);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_divider_first_r <= `CG_RST_DIV_FIRST;
    end else if (wr && wb_adr_i == `CG_OFS_DIV_FIRST) begin
      clock_divider_first_r <= merge_write(clock_divider_first_r, wb_dat_i, wb_sel_i,
                                           `CG_MASK_DIV_FIRST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_divider_second_r <= `CG_RST_DIV_SECOND;
    end else if (wr && wb_adr_i == `CG_OFS_DIV_SECOND) begin
      clock_divider_second_r <= merge_write(clock_divider_second_r, wb_dat_i, wb_sel_i,
                                            `CG_MASK_DIV_SECOND);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_control_r <= `CG_RST_PLL;
    end else if (wr && wb_adr_i == `CG_OFS_PLL) begin
      pll_control_r <= merge_write(pll_control_r, wb_dat_i, wb_sel_i, `CG_MASK_PLL);
    end
  end

  // ----------------------------------------------------------------
  // pll control pins, one register stage from the control fields
  // ----------------------------------------------------------------
  // factors: ref 2*(field+2), loop 2*(field+2), post 1/2/2/4, decoded inside the pll
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_out_off_o <= 1'b0;
      pll_bypass_o <= 1'b0;
      pll_power_down_o <= 1'b0;
      pll_post_div_o <= 2'h0;
      pll_ref_div_o <= 5'h00;
      pll_loop_div_o <= 9'h000;
    end else begin
      pll_out_off_o <= pll_control_r[`PLL_OUT_OFF];
      pll_bypass_o <= pll_control_r[`PLL_BYPASS];
      pll_power_down_o <= pll_control_r[`PLL_POWER_DOWN];
      pll_post_div_o <= pll_control_r[`PLL_POST_DIV];
      pll_ref_div_o <= pll_control_r[`PLL_REF_DIV];
      pll_loop_div_o <= pll_control_r[`PLL_LOOP_DIV];
    end
  end

  // ----------------------------------------------------------------
  // source clocks from the pins
  // ----------------------------------------------------------------
  // sources are sampled at clk_i, so each must stay below half its rate
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic xtal_s;
  logic rtc_s;
  logic pll_s;
  logic xtal_prev_r;
  logic rtc_prev_r;
  logic pll_eff_r;
  logic pll_prev_r;
  logic [3:0] src_edges;

  assign async_in = {pll_clk_i, rtc_xtal_clk_i, xtal_clk_i};
  assign xtal_s = sync2_r[0];
  assign rtc_s = sync2_r[1];
  assign pll_s = sync2_r[2];

  generate
    for (genvar s = 0; s < NSYNC; s++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_r[s] <= 1'b0;
          sync2_r[s] <= 1'b0;
        end else begin
          sync1_r[s] <= async_in[s];
          sync2_r[s] <= sync1_r[s];
        end
      end
    end
  endgenerate

  // the pll output as seen downstream: held low, bypassed, or running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_eff_r <= 1'b0;
    end else if (pll_control_r[`PLL_OUT_OFF]) begin
      pll_eff_r <= 1'b0;
    end else if (pll_control_r[`PLL_BYPASS]) begin
      pll_eff_r <= xtal_s;
    end else begin
      pll_eff_r <= pll_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_prev_r <= 1'b0;
      rtc_prev_r <= 1'b0;
      pll_prev_r <= 1'b0;
      pll_ref_clk_o <= 1'b0;
    end else begin
      xtal_prev_r <= xtal_s;
      rtc_prev_r <= rtc_s;
      pll_prev_r <= pll_eff_r;
      pll_ref_clk_o <= xtal_s;
    end
  end

  // halved pll toggles on every pll rising edge, so those are its edges
  assign src_edges[SRC_XTAL] = xtal_s ^ xtal_prev_r;
  assign src_edges[SRC_PLL] = pll_eff_r ^ pll_prev_r;
  assign src_edges[SRC_PLL_HALF] = pll_eff_r & ~pll_prev_r;
  assign src_edges[SRC_RTC32] = rtc_s ^ rtc_prev_r;

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic hclk_raw;
  logic hclk_edge;
  logic pclk_raw;
  logic usb_raw;
  logic adc_raw;
  logic [5:0] pending;

  clock_divider #(.W(4)) u_core_bus_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i(src_edges),
    .sel_i(src_t'(clock_source_select_r[`CORE_BUS_SRC_SEL])),
    .div_i(clock_divider_first_r[`CORE_BUS_DIV]),
    .halve_i(1'b1),
    .clk_o(hclk_raw),
    .edge_o(hclk_edge),
    .pending_o(pending[0])
  );

  clock_divider #(.W(2)) u_periph_bus_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i({4{hclk_edge}}),
    .sel_i(SRC_XTAL),
    .div_i(clock_divider_first_r[`PERIPH_BUS_DIV]),
    .halve_i(1'b0),
    .clk_o(pclk_raw),
    .edge_o(),
    .pending_o(pending[1])
  );

  clock_divider #(.W(4)) u_usb_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i(src_edges),
    .sel_i(periph_src(clock_source_select_r[`USB_SRC_SEL])),
    .div_i(clock_divider_first_r[`USB_DIV]),
    .halve_i(1'b0),
    .clk_o(usb_raw),
    .edge_o(),
    .pending_o(pending[2])
  );

  clock_divider #(.W(4)) u_serial_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i(src_edges),
    .sel_i(periph_src(clock_source_select_r[`SERIAL_SRC_SEL])),
    .div_i(clock_divider_first_r[`SERIAL_DIV]),
    .halve_i(1'b0),
    .clk_o(uart_clk_o),
    .edge_o(),
    .pending_o(pending[3])
  );

  clock_divider #(.W(8)) u_audio_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i(src_edges),
    .sel_i(periph_src(clock_source_select_r[`AUDIO_SRC_SEL])),
    .div_i(clock_divider_first_r[`AUDIO_DIV]),
    .halve_i(1'b0),
    .clk_o(audio_clk_o),
    .edge_o(),
    .pending_o(pending[4])
  );

  clock_divider #(.W(8)) u_converter_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .edge_i(src_edges),
    .sel_i(periph_src(clock_source_select_r[`CONVERTER_SRC_SEL])),
    .div_i(clock_divider_second_r[`CONVERTER_DIV]),
    .halve_i(1'b0),
    .clk_o(adc_raw),
    .edge_o(),
    .pending_o(pending[5])
  );

  assign hclk_o = hclk_raw;

  // ----------------------------------------------------------------
  // clock gates
  // ----------------------------------------------------------------
  logic [NGATE-1:0] gate_src;
  logic [NGATE-1:0] gate_en;
  logic [NGATE-1:0] gate_out;

  always_comb begin
    gate_src = '0;
    gate_en = '0;
    for (int p = 0; p < `PERIPH_GATES; p++) begin
      gate_src[p] = pclk_raw;
      gate_en[p] = peripheral_clock_enables_r[p];
    end
    gate_en[`PERIPH_SPARE] = 1'b0;
    gate_src[`WATCHDOG_CLOCK_ON] = xtal_s;
    gate_src[`TIMER_CLOCK_ON] = xtal_s;
    gate_src[G_CPU] = hclk_raw;
    gate_en[G_CPU] = bus_clock_enables_r[`PROCESSOR_CLOCK_ON];
    gate_src[G_PCLK] = pclk_raw;
    gate_en[G_PCLK] = bus_clock_enables_r[`PERIPH_BUS_CLOCK_ON];
    gate_src[G_USB] = usb_raw;
    gate_en[G_USB] = bus_clock_enables_r[`USB_DEVICE_CLOCK_ON];
    gate_src[G_ADC] = adc_raw;
    gate_en[G_ADC] = peripheral_clock_enables_r[`CONVERTER_CLOCK_ON];
  end

  // the enable is sampled only while the source is low, so a gate can
  // neither cut a high phase short nor start one midway
  generate
    for (genvar g = 0; g < NGATE; g++) begin : g_gate
      logic hold_r;
      logic out_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hold_r <= 1'b0;
          out_r <= 1'b0;
        end else begin
          if (!gate_src[g]) begin
            hold_r <= gate_en[g];
          end
          out_r <= gate_src[g] & hold_r;
        end
      end
      assign gate_out[g] = out_r;
    end
  endgenerate

  assign periph_clk_o = gate_out[`PERIPH_GATES-1:0];
  assign cpu_clk_o = gate_out[G_CPU];
  assign pclk_o = gate_out[G_PCLK];
  assign usb_clk_o = gate_out[G_USB];
  assign adc_clk_o = gate_out[G_ADC];

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (wb_adr_i)
      `CG_OFS_BUS_EN: rd_data = bus_clock_enables_r;
      `CG_OFS_PERIPH_EN: rd_data = peripheral_clock_enables_r;
      `CG_OFS_SRC_SEL: rd_data = clock_source_select_r;
      `CG_OFS_DIV_FIRST: rd_data = clock_divider_first_r;
      `CG_OFS_DIV_SECOND: rd_data = clock_divider_second_r;
      `CG_OFS_PLL: rd_data = pll_control_r;
      `CG_OFS_STATUS: rd_data = {23'h00_0000, pll_eff_r, 2'h0, pending};
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule : chip_clock_gen_control

// ### dv/clkgen_asserts.sv
// checker for the clock generator: bus handshake, pll fields and clock gates.
// assumes bind to chip_clock_gen_control; full-lane writes keep the gate shadows exact.
module clkgen_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic pll_out_off_o,
  input wire logic pll_bypass_o,
  input wire logic pll_power_down_o,
  input wire logic [1:0] pll_post_div_o,
  input wire logic [4:0] pll_ref_div_o,
  input wire logic [8:0] pll_loop_div_o,
  input wire logic hclk_o,
  input wire logic cpu_clk_o,
  input wire logic pclk_o,
  input wire logic usb_clk_o,
  input wire logic [9:0] periph_clk_o
);
  logic wr;
  logic wq;
  logic [18:0] pf;
  logic [31:0] pw_r;
  logic [9:0] pen_r;
  logic [2:0] ben_r;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & (wb_sel_i == 4'hF);
  assign wq = wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == 8'h20);
  assign pf = {pll_out_off_o, pll_bypass_o, pll_power_down_o, pll_post_div_o,
               pll_ref_div_o, pll_loop_div_o};
  // shadows lag the design by one cycle, so the gate checks allow one cycle of slack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_r <= 10'h007;
      ben_r <= 3'h3;
    end else if (wr && wb_adr_i == 8'h08) begin
      pen_r <= wb_dat_i[9:0];
    end else if (wr && wb_adr_i == 8'h04) begin
      ben_r <= {wb_dat_i[6], wb_dat_i[1:0]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (wr && wb_adr_i == 8'h20) begin
      pw_r <= wb_dat_i;
    end
  end
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_rdata_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved");
  a_pll_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr && wb_adr_i == 8'h20 |=> pf == pw_r[18:0]) else $error("pll pins differ");
  a_pll_only_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $changed(pf) |-> $past(wq) || $past(wq, 2) || $past(rst_i) || $past(rst_i, 2))
    else $error("pll pins moved");
  a_periph_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (periph_clk_o & ~$past(periph_clk_o) & ~pen_r & ~$past(pen_r)) == 10'h000)
    else $error("closed gate pulsed");
  a_bus_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ({usb_clk_o, pclk_o, cpu_clk_o} & ~$past({usb_clk_o, pclk_o, cpu_clk_o})
     & ~ben_r & ~$past(ben_r)) == 3'h0) else $error("closed bus gate pulsed");
  a_spare_low: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_clk_o[7] == 1'b0) else $error("spare gate active");
endmodule : clkgen_asserts

bind chip_clock_gen_control clkgen_asserts chk (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
  .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .pll_out_off_o,
  .pll_bypass_o, .pll_power_down_o, .pll_post_div_o, .pll_ref_div_o, .pll_loop_div_o,
  .hclk_o, .cpu_clk_o, .pclk_o, .usb_clk_o, .periph_clk_o);

// ### dv/chip_clock_gen_control_tb_top.sv
// bench for the clock generator: registers, pll pins, selects, dividers and gates.
// assumes crystal 12.5 MHz, pll pin 16.7 MHz and a slow 32 kHz stand-in made here.
module chip_clock_gen_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic xtal_clk_i = 0, rtc_xtal_clk_i = 0, pll_clk_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_ack_o, pll_ref_clk_o, pll_out_off_o, pll_bypass_o, pll_power_down_o;
  logic hclk_o, cpu_clk_o, pclk_o, usb_clk_o, uart_clk_o, audio_clk_o, adc_clk_o;
  logic [1:0] pll_post_div_o;
  logic [4:0] pll_ref_div_o;
  logic [8:0] pll_loop_div_o;
  logic [9:0] periph_clk_o;
  int miscompares = 0, n_compared = 0;
  logic [7:0] ofs[7] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h0C};
  logic [31:0] rv[7] = '{32'h3, 32'h7, 32'h0, 32'h0, 32'h0, 32'h14035, 32'h0};
  logic [31:0] mk[7] = '{32'h43, 32'h37F, 32'hC0FF, 32'hFFFFCF, 32'hFF0000, 32'h7FFFF, 32'h0};

  // edges kept off the system clock rising edges so every source period is exact in cycles
  initial forever #5 clk_i = ~clk_i;
  initial begin #3; forever #40 xtal_clk_i = ~xtal_clk_i; end
  initial begin #7; forever #30 pll_clk_i = ~pll_clk_i; end
  initial forever #1000 rtc_xtal_clk_i = ~rtc_xtal_clk_i;

  chip_clock_gen_control uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .xtal_clk_i, .rtc_xtal_clk_i, .pll_clk_i,
    .pll_ref_clk_o, .pll_out_off_o, .pll_bypass_o, .pll_power_down_o, .pll_post_div_o,
    .pll_ref_div_o, .pll_loop_div_o, .hclk_o, .cpu_clk_o, .pclk_o, .usb_clk_o,
    .uart_clk_o, .audio_clk_o, .adc_clk_o, .periph_clk_o);

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      results();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rc

  function automatic logic sig(input int i);
    logic [17:0] v;
    v = {periph_clk_o, adc_clk_o, audio_clk_o, uart_clk_o, usb_clk_o, pclk_o, cpu_clk_o,
         hclk_o, pll_ref_clk_o};
    return v[i];
  endfunction : sig

  // period of the third interval, so select and divider hand-overs have settled
  task automatic per(input string nm, input int i, input int e);
    logic p;
    int r[$];
    p = sig(i);
    for (int c = 0; c < 2200 && r.size() < 4; c++) begin
      @(negedge clk_i);
      if (sig(i) === 1'b1 && p === 1'b0) r.push_back(c);
      p = sig(i);
    end
    chk(nm, e, r.size() < 4 ? 0 : r[3] - r[2]);
  endtask : per

  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      rc(ofs[i], rv[i]);
      wr(ofs[i], 32'hFFFFFFFF);
      rc(ofs[i], mk[i]);
      wr(ofs[i], rv[i]);
    end
    wr(8'h20, 32'h0, 4'h2);
    rc(8'h20, 32'h10035);
    $display("registers done");
    // all-ones writes may leave slow dividers mid hand-over; start the clock tests clean
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // ref field 5 and loop field 0xC5 keep both pll ranges for a 12.5 MHz crystal
    for (int c = 0; c < 4; c++) begin
      v = {13'h0000, c[0], ~c[0], c[1], c[1:0], 5'h05, 9'h0C5};
      wr(8'h20, v);
      @(posedge clk_i);
      chk("pll pins", v[18:0], {pll_out_off_o, pll_bypass_o, pll_power_down_o,
          pll_post_div_o, pll_ref_div_o, pll_loop_div_o});
    end
    per("ref clock", 0, 8);
    // the last loop pass holds the pll output low; let it run again before any reselection
    wr(8'h20, 32'h14035);
    $display("pll done");
    // every source runs from here on, so any reselection is safe
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, c);
      per("core clock", 1, c == 0 ? 16 : c == 1 ? 12 : c == 2 ? 24 : 400);
    end
    wr(8'h10, 32'h1);
    wr(8'h14, 32'hF);
    per("core clock max", 1, 192);
    wr(8'h14, 32'hF201C0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, (c << 6) | 32'hC024);
      per("uart clock", 5, c == 0 ? 24 : c == 1 ? 18 : 36);
    end
    per("periph bus", 3, 64);
    per("audio clock", 6, 24);
    $display("dividers done");
    per("usb closed", 4, 0);
    per("adc closed", 7, 0);
    per("uart0 closed", 11, 0);
    per("timer clock", 8, 8);
    wr(8'h08, 32'h37F);
    wr(8'h04, 32'h43);
    per("usb clock", 4, 96);
    per("adc clock", 7, 12);
    per("uart0 gate", 11, 64);
    per("spi gate", 16, 64);
    wr(8'h08, 32'h4);
    per("rtc gate", 10, 64);
    per("timer off", 8, 0);
    per("watchdog off", 9, 0);
    wr(8'h04, 32'h42);
    per("cpu off", 2, 0);
    $display("gates done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rc(8'h08, 32'h7);
    $display("second reset done");
    results();
  end
endmodule : chip_clock_gen_control_tb_top
